//--- rtl/acmp_top.v
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "acmp_consts.vh"
// Functional notes
// - result high only when positive exceeds negative
// - comparator works only with enable bit 3
// - disabled: result low, flag never set
// - flag bit 4 set by match, software clears
// - mode bits 2..0 select eight conditions
// - result sampled every system clock
// - debounced: two overflows, resample, confirm
// - idle stops comparator unless bit 5 set
// - idle event with interrupt enabled wakes cpu
// - power-down always disables comparator
// - interrupt request needs enable register bit 6
// - control resets low five bits cleared
module acmp_top (
    input wire aclk,
    input wire aresetn,
    input wire cmp_raw,
    input wire timer_ovf,
    input wire [31:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg cmp_result,
    output reg cmp_irq_req,
    output reg idle_wake,
    output reg irq
);
    // cmp_raw is the analog comparator's digital output (pos > neg)
    wire cmp_sync;
    reg [2:0] condition_mode_field;
    reg comparator_enable;
    reg comparator_event_flag;
    reg run_in_idle;
    reg [7:0] interrupt_enable_reg;
    reg idle_mode;
    reg power_down;
    reg prev_result;
    reg [1:0] irq_status;
    reg [1:0] irq_mask;
    reg have_aw;
    reg have_w;
    reg [11:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire active;
    wire cur;
    wire rise;
    wire fall;
    wire db_confirm;
    wire db_busy;
    reg db_start;
    reg db_expect;
    reg direct_hit;
    wire event_set;
    wire wr_go;
    wire rd_go;
    wire sw_flag_clear;
    wire [11:0] ar_addr;
    reg [31:0] next_rdata;
    wire [7:0] ctrl_status_view;
    // reset image of the control/status byte, split into its fields below
    localparam [7:0] CTRL_RST = `ACMP_CTRL_RESET;

    // one decode of the mapped offsets, shared by both response paths
    function acmp_mapped;
        input [11:0] addr;
        begin
            acmp_mapped = (addr == `ACMP_ADDR_CTRL_STATUS)
                || (addr == `ACMP_ADDR_INT_ENABLE)
                || (addr == `ACMP_ADDR_IRQ_STATUS)
                || (addr == `ACMP_ADDR_IRQ_MASK)
                || (addr == `ACMP_ADDR_POWER);
        end
    endfunction

    // both stages reset low, so no false rise after reset
    // pin level synchronised
    acmp_sync2 #(
        .WIDTH(1)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(cmp_raw),
        .dout(cmp_sync)
    );

    assign active = comparator_enable & ~power_down & (~idle_mode | run_in_idle);
    assign cur = active & cmp_sync;
    // enabling with a high input shows as a rise, hence the settle time
    assign rise = cur & ~prev_result;
    assign fall = ~cur & prev_result;

    // sample every clock; result follows gated level
    always @(posedge aclk) begin
        if (!aresetn) begin
            prev_result <= 1'b0;
            cmp_result <= 1'b0;
        end else begin
            prev_result <= cur;
            cmp_result <= cur;
        end
    end

    always @* begin
        direct_hit = 1'b0;
        db_start = 1'b0;
        db_expect = 1'b0;
        case (condition_mode_field)
            `ACMP_M_LOW: direct_hit = ~cur;
            `ACMP_M_RISE: direct_hit = rise;
            `ACMP_M_FALL: direct_hit = fall;
            `ACMP_M_TOG: direct_hit = rise | fall;
            `ACMP_M_HIGH: direct_hit = cur;
            `ACMP_M_DB_TOG: begin
                db_start = rise | fall;
                db_expect = cur;
            end
            `ACMP_M_DB_RISE: begin
                db_start = rise;
                db_expect = 1'b1;
            end
            `ACMP_M_DB_FALL: begin
                db_start = fall;
                db_expect = 1'b0;
            end
            default: direct_hit = 1'b0;
        endcase
    end

    // debounce wait, no rearm while busy
    acmp_debounce u_db (
        .aclk(aclk),
        .aresetn(aresetn),
        .active(active),
        .start(db_start),
        .expected(db_expect),
        .ovf_pulse(timer_ovf),
        .sample(cur),
        .confirm(db_confirm),
        .busy(db_busy)
    );

    // debounce confirms arrive a cycle late and are gated again here
    // no events while inactive
    assign event_set = active & (direct_hit | db_confirm);

    // axi handshakes
    // a write waits while its response is still unanswered
    assign wr_go = have_aw & have_w & ~s_axi_bvalid;
    // reads are taken only through the one-cycle arready pulse
    assign rd_go = s_axi_arvalid & s_axi_arready;
    assign ar_addr = s_axi_araddr[11:0];
    assign sw_flag_clear = wr_go && aw_addr == `ACMP_ADDR_CTRL_STATUS && w_strb[0]
        && !w_data[`ACMP_FLAG_BIT];
    // upper two bits reserved, read as zero
    assign ctrl_status_view = {2'h0, run_in_idle, comparator_event_flag,
        comparator_enable, condition_mode_field};

    // write channel capture, either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            have_aw <= 1'b0;
            have_w <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            s_axi_awready <= ~have_aw & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~have_w & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                have_aw <= 1'b1;
                aw_addr <= s_axi_awaddr[11:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                have_w <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                have_aw <= 1'b0;
                have_w <= 1'b0;
            end
        end
    end

    // register writes; hardware set beats software clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            // fields start from the reset image: disabled, low level
            condition_mode_field <= CTRL_RST[`ACMP_MODE_MSB:`ACMP_MODE_LSB];
            comparator_enable <= CTRL_RST[`ACMP_EN_BIT];
            comparator_event_flag <= CTRL_RST[`ACMP_FLAG_BIT];
            run_in_idle <= CTRL_RST[`ACMP_IDLE_BIT];
            interrupt_enable_reg <= 8'h00;
            idle_mode <= 1'b0;
            power_down <= 1'b0;
            irq_mask <= 2'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                // unmapped offsets answer with a slave error
                s_axi_bresp <= acmp_mapped(aw_addr) ? 2'h0 : 2'h2;
                case (aw_addr)
                    `ACMP_ADDR_CTRL_STATUS: if (w_strb[0]) begin
                        condition_mode_field <= w_data[`ACMP_MODE_MSB:`ACMP_MODE_LSB];
                        comparator_enable <= w_data[`ACMP_EN_BIT];
                        run_in_idle <= w_data[`ACMP_IDLE_BIT];
                    end
                    `ACMP_ADDR_INT_ENABLE: if (w_strb[0])
                        interrupt_enable_reg <= w_data[7:0];
                    `ACMP_ADDR_IRQ_MASK: if (w_strb[0])
                        irq_mask <= w_data[1:0];
                    `ACMP_ADDR_POWER: if (w_strb[0]) begin
                        idle_mode <= w_data[`ACMP_PWR_IDLE_BIT];
                        power_down <= w_data[`ACMP_PWR_DOWN_BIT];
                    end
                    default: s_axi_bresp <= 2'h2;
                endcase
            end
            if (event_set)
                comparator_event_flag <= 1'b1;
            else if (sw_flag_clear)
                comparator_event_flag <= 1'b0;
            // idle_wake has already seen idle before idle_mode drops
            // a comparator interrupt request (cmp_irq_req) leaves idle; irq does not
            if (cmp_irq_req && idle_mode)
                idle_mode <= 1'b0;
        end
    end

    // read channel; status cleared on read, new events win
    always @* begin
        case (ar_addr)
            `ACMP_ADDR_CTRL_STATUS: next_rdata = {24'h000000, ctrl_status_view};
            `ACMP_ADDR_INT_ENABLE: next_rdata = {24'h000000, interrupt_enable_reg};
            `ACMP_ADDR_IRQ_STATUS: next_rdata = {30'h0, irq_status};
            `ACMP_ADDR_IRQ_MASK: next_rdata = {30'h0, irq_mask};
            `ACMP_ADDR_POWER: next_rdata = {30'h0, power_down, idle_mode};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
            irq_status <= 2'h0;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                // unmapped offsets answer with a slave error
                s_axi_rresp <= acmp_mapped(ar_addr) ? 2'h0 : 2'h2;
            end
            // bit0 any match, bit1 flag newly raised; a same-cycle event beats the clear
            irq_status <= ((rd_go && ar_addr == `ACMP_ADDR_IRQ_STATUS) ? 2'h0 : irq_status)
                | {event_set & ~comparator_event_flag, event_set};
        end
    end

    // request gated by enable bit 6, outputs registered
    always @(posedge aclk) begin
        if (!aresetn) begin
            cmp_irq_req <= 1'b0;
            idle_wake <= 1'b0;
            irq <= 1'b0;
        end else begin
            cmp_irq_req <= comparator_event_flag & interrupt_enable_reg[`ACMP_IE_CMP_BIT];
            // without the run bit nothing can fire in idle, so it is required here
            idle_wake <= comparator_event_flag & interrupt_enable_reg[`ACMP_IE_CMP_BIT]
                & idle_mode & run_in_idle;
            irq <= |(irq_status & irq_mask);
        end
    end
endmodule // acmp_top

//--- pkg/acmp_consts.vh
`ifndef ACMP_CONSTS_VH
`define ACMP_CONSTS_VH
// register byte addresses (printed offset 0x97 is not a multiple of four)
`define ACMP_IDX_CTRL_STATUS 8'h97
`define ACMP_ADDR_CTRL_STATUS 12'h25c
`define ACMP_ADDR_INT_ENABLE 12'h000
`define ACMP_ADDR_IRQ_STATUS 12'h004
`define ACMP_ADDR_IRQ_MASK 12'h008
`define ACMP_ADDR_POWER 12'h00c
// control/status field positions
`define ACMP_MODE_LSB 0
`define ACMP_MODE_MSB 2
`define ACMP_EN_BIT 3
`define ACMP_FLAG_BIT 4
`define ACMP_IDLE_BIT 5
`define ACMP_IE_CMP_BIT 6
`define ACMP_CTRL_RESET 8'h00
// condition modes
`define ACMP_M_LOW 3'h0
`define ACMP_M_RISE 3'h1
`define ACMP_M_DB_TOG 3'h2
`define ACMP_M_DB_RISE 3'h3
`define ACMP_M_FALL 3'h4
`define ACMP_M_TOG 3'h5
`define ACMP_M_DB_FALL 3'h6
`define ACMP_M_HIGH 3'h7
// overflows waited for before resampling
`define ACMP_DB_OVF_COUNT 2'h2
// power bits
`define ACMP_PWR_IDLE_BIT 0
`define ACMP_PWR_DOWN_BIT 1
`endif

//--- rtl/acmp_sync2.v
`timescale 1ns/1ns
// two flip-flop synchroniser for pin levels
module acmp_sync2 #(
    parameter WIDTH = 1
) (
    input wire aclk,
    input wire aresetn,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta;

    // first stage feeds only the second
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // acmp_sync2

//--- rtl/acmp_debounce.v
`timescale 1ns/1ns
`include "acmp_consts.vh"
// debounce wait: arm on transition, count overflows, resample once
module acmp_debounce (
    input wire aclk,
    input wire aresetn,
    input wire active,
    input wire start,
    input wire expected,
    input wire ovf_pulse,
    input wire sample,
    output reg confirm,
    output reg busy
);
    reg [1:0] ovf_cnt;
    reg want;

    // while busy a new start is ignored
    always @(posedge aclk) begin
        if (!aresetn) begin
            busy <= 1'b0;
            ovf_cnt <= 2'h0;
            want <= 1'b0;
            confirm <= 1'b0;
        end else begin
            confirm <= 1'b0;
            if (!active) begin
                busy <= 1'b0;
                ovf_cnt <= 2'h0;
            end else if (!busy) begin
                if (start) begin
                    busy <= 1'b1;
                    ovf_cnt <= 2'h0;
                    want <= expected;
                end
            end else if (ovf_cnt == `ACMP_DB_OVF_COUNT) begin
                // resample after second overflow; mismatch drops the event
                busy <= 1'b0;
                confirm <= (sample == want);
            end else if (ovf_pulse) begin
                ovf_cnt <= ovf_cnt + 2'h1;
            end
        end
    end
endmodule // acmp_debounce

//--- tb/acmp_far.sv
`timescale 1ns/1ns
// far side: analog inputs and a free-running timer overflow
module acmp_far (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] pos_mv,
    input wire [7:0] neg_mv,
    output reg cmp_raw,
    output reg timer_ovf
);
reg [3:0] tcnt = 4'h0;
always @(posedge aclk) begin
    cmp_raw <= pos_mv > neg_mv;
    tcnt <= aresetn ? tcnt + 4'h1 : 4'h0;
    // short period keeps debounce waits cheap
    timer_ovf <= aresetn && tcnt == 4'hf;
end
endmodule // acmp_far

//--- tb/acmp_top_assertions.sv
`timescale 1ns/1ns
// port-level checks on the comparator block
module acmp_chk (
    input wire aclk,
    input wire aresetn,
    input wire cmp_raw,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire cmp_result,
    input wire cmp_irq_req,
    input wire idle_wake,
    input wire irq
);
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
sequence s_wt; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
sequence s_rt; s_axi_arvalid && s_axi_arready; endsequence
property p_rst; $rose(aresetn) |-> !cmp_result && !cmp_irq_req && !irq && !idle_wake; endproperty
a_rst: assert property (p_rst) else $error("outputs not low after reset");
property p_res; $rose(cmp_result) |-> $past(cmp_raw, 2) || $past(cmp_raw, 3); endproperty
a_res: assert property (p_res) else $error("result rose without raw high");
property p_wake; idle_wake |-> cmp_irq_req || $past(cmp_irq_req); endproperty
a_wake: assert property (p_wake) else $error("wake without request");
property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
a_rhold: assert property (p_rhold) else $error("rvalid dropped early");
property p_bans; s_wt |-> ##2 s_axi_bvalid; endproperty
a_bans: assert property (p_bans) else $error("no write response");
property p_rans; s_rt |=> s_axi_rvalid; endproperty
a_rans: assert property (p_rans) else $error("no read response");
property p_bone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
a_bone: assert property (p_bone) else $error("repeated write response");
endmodule // acmp_chk
bind acmp_top acmp_chk u_chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .cmp_raw(cmp_raw),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .cmp_result(cmp_result),
    .cmp_irq_req(cmp_irq_req),
    .idle_wake(idle_wake),
    .irq(irq)
);

//--- tb/comparator_event_logic_test.sv
`timescale 1ns/1ns
`include "acmp_consts.vh"
module comparator_event_logic_test;
reg aclk = 1'b0;
reg aresetn = 1'b0;
reg awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0, ok, w;
reg [31:0] awa = 32'h0, ara = 32'h0, wd = 32'h0, d;
reg [7:0] pos = 8'h00;
reg [1:0] r;
wire raw, ovf, awr, wrd, bv, arr, rv, res, req, wake, irq;
wire [1:0] br, rr;
wire [31:0] rdat;
integer err_total = 0, total_checks = 0, i, n;
localparam [11:0] CS = `ACMP_ADDR_CTRL_STATUS;
// 25 MHz clock
always #20 aclk = ~aclk;
acmp_far far (.aclk(aclk), .aresetn(aresetn), .pos_mv(pos), .neg_mv(8'h80), .cmp_raw(raw),
    .timer_ovf(ovf));
acmp_top dut (.aclk(aclk), .aresetn(aresetn), .cmp_raw(raw), .timer_ovf(ovf),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .cmp_result(res),
    .cmp_irq_req(req), .idle_wake(wake), .irq(irq));
task complete_run;
    begin
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
endtask
task hang;
    begin
        err_total = err_total + 1;
        complete_run;
    end
endtask
task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
        total_checks = total_checks + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
        end
    end
endtask
task cyc(input integer k);
    repeat (k) @(posedge aclk);
endtask
// write: address and data offered together, each dropped once taken
task wr(input [11:0] a, input [31:0] v);
    begin
        @(posedge aclk);
        awa <= {20'h0, a};
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        ok = 1'b0;
        for (n = 0; !ok; n = n + 1) begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (bv) begin
                ok = 1'b1;
                brdy <= 1'b0;
                r = br;
            end
            if (n == 99) hang;
        end
    end
endtask
task rd(input [11:0] a);
    begin
        @(posedge aclk);
        ara <= {20'h0, a};
        arv <= 1'b1;
        rrdy <= 1'b1;
        ok = 1'b0;
        for (n = 0; !ok; n = n + 1) begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
            if (rv) begin
                ok = 1'b1;
                rrdy <= 1'b0;
                d = rdat;
                r = rr;
            end
            if (n == 99) hang;
        end
    end
endtask
task t_reset;
    begin
        rd(CS);
        chk("ctrl", 32'h0, d);
        rd(12'h0f0);
        chk("unmap", 32'h2, {30'h0, r});
        pos <= 8'hff;
        wr(CS, 32'h07);
        chk("wr_resp", 32'h0, {30'h0, r});
        wr(12'h0f0, 32'h0);
        chk("wr_unmap", 32'h2, {30'h0, r});
        cyc(12);
        chk("res_off", 32'h0, {31'h0, res});
        rd(CS);
        chk("flag_off", 32'h0, {31'h0, d[4]});
        pos <= 8'h00;
    end
endtask
// every mode: flag after low level, rise, fall (cleared before the low and fall checks)
task t_modes;
    begin
        for (i = 0; i < 8; i = i + 1) begin
            wr(CS, 32'h08 | i);
            cyc(60);
            wr(CS, 32'h08 | i);
            cyc(8);
            rd(CS);
            chk("low", {24'h0, (8'h01 >> i) & 8'h01}, {31'h0, d[4]});
            chk("mode", i, {29'h0, d[2:0]});
            pos <= 8'hff;
            cyc(70);
            chk("res_on", 32'h1, {31'h0, res});
            rd(CS);
            chk("rise", {24'h0, (8'haf >> i) & 8'h01}, {31'h0, d[4]});
            wr(CS, 32'h08 | i);
            pos <= 8'h00;
            cyc(70);
            rd(CS);
            chk("fall", {24'h0, (8'hf5 >> i) & 8'h01}, {31'h0, d[4]});
        end
    end
endtask
// short glitch must be dropped by the debounced rise mode
task t_debounce;
    begin
        wr(CS, 32'h0b);
        pos <= 8'hff;
        cyc(6);
        pos <= 8'h00;
        cyc(70);
        rd(CS);
        chk("glitch", 32'h0, {31'h0, d[4]});
        // debounced toggle: the fall inside the wait must not start a new wait
        wr(CS, 32'h0a);
        pos <= 8'hff;
        cyc(6);
        pos <= 8'h00;
        cyc(70);
        rd(CS);
        chk("no_rearm", 32'h0, {31'h0, d[4]});
    end
endtask
task t_irq;
    begin
        wr(CS, 32'h09);
        cyc(250);
        rd(`ACMP_ADDR_IRQ_STATUS);
        wr(CS, 32'h09);
        wr(`ACMP_ADDR_INT_ENABLE, 32'h40);
        wr(`ACMP_ADDR_IRQ_MASK, 32'h1);
        pos <= 8'hff;
        cyc(10);
        chk("req", 32'h1, {31'h0, req});
        chk("irq", 32'h1, {31'h0, irq});
        rd(`ACMP_ADDR_IRQ_STATUS);
        chk("sts", 32'h1, {31'h0, d[0]});
        cyc(2);
        chk("irq_clr", 32'h0, {31'h0, irq});
        wr(`ACMP_ADDR_INT_ENABLE, 32'h0);
        cyc(2);
        chk("req_off", 32'h0, {31'h0, req});
        pos <= 8'h00;
    end
endtask
// idle without run bit, idle with it, power-down with it
task t_idle;
    begin
        for (i = 0; i < 3; i = i + 1) begin
            wr(CS, (i > 0) ? 32'h29 : 32'h09);
            wr(`ACMP_ADDR_INT_ENABLE, 32'h40);
            wr(`ACMP_ADDR_POWER, (i == 2) ? 32'h2 : 32'h1);
            pos <= 8'hff;
            w = 1'b0;
            repeat (20) begin
                @(posedge aclk);
                w = w | wake;
            end
            pos <= 8'h00;
            wr(`ACMP_ADDR_POWER, 32'h0);
            rd(CS);
            chk("idle_flg", (i == 1), {31'h0, d[4]});
            chk("wake", (i == 1), {31'h0, w});
        end
    end
endtask
initial begin
    cyc(16);
    aresetn <= 1'b1;
    t_reset;
    t_modes;
    t_debounce;
    t_irq;
    t_idle;
    complete_run;
end
endmodule // comparator_event_logic_test
